// file: logic/fan_temp_regs.sv
`timescale 1ns/1ps
`include "fan_ctrl_consts.svh"
module fan_temp_regs #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output fan_ctrl_pkg::resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output fan_ctrl_pkg::resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// temperature sources
	input wire fan_ctrl_pkg::temp9_t cpu_temp_input,
	input wire fan_ctrl_pkg::temp9_t peci_temp,
	input wire fan_ctrl_pkg::temp9_t sys_temp_input,
	input wire logic temp_sample,
	// fan drive and sensing
	output fan_ctrl_pkg::reg8_t cpu_fan_drive_out,
	output fan_ctrl_pkg::reg8_t sys_fan_drive_out,
	output logic over_temp_alert_n,
	output logic cpu_sense_current_mode,
	output logic sys_sense_current_mode,
	output logic cpu_sensor_type_select,
	output logic sys_sensor_type_select
);
	import fan_ctrl_pkg::*;

	reg8_t crit_en, max_out, step_val, sys_crit, cpu_crit, cfg;
	reg8_t hyst_hi, hyst_lo, ovt_hi, ovt_lo, sense_type, src_sel;
	reg8_t mode_reg, cpu_target, cpu_base, sys_base;
	reg8_t next_crit_en, next_max_out, next_step_val, next_sys_crit, next_cpu_crit;
	reg8_t next_cfg, next_hyst_hi, next_hyst_lo, next_ovt_hi, next_ovt_lo;
	reg8_t next_sense_type, next_src_sel, next_mode_reg, next_cpu_target;
	reg8_t next_cpu_base, next_sys_base;
	temp9_t cpu_reading, sys_reading, next_cpu_reading, next_sys_reading, src_temp;
	logic aw_full, w_full, next_aw_full, next_w_full, next_bvalid;
	logic [7:0] aw_idx, next_aw_idx, wbyte, next_wbyte;
	logic aw_hit, next_aw_hit, wstrb0, next_wstrb0;
	resp_t next_bresp;
	logic do_write, wr_en, ar_take, next_rvalid, next_arready;
	logic [31:0] next_rdata;
	resp_t next_rresp;
	reg8_t next_cpu_fan, next_sys_fan;
	logic [8:0] fan_sum;
	reg8_t fan_up, fan_dn, fan_hold;
	fan_mode_t fan_mode;
	logic stop;

	alert_if aif();

	function automatic logic mapped(input logic [7:0] idx);
		case (idx)
			`IDX_SRC_SEL, `IDX_CPU_RD_HI, `IDX_CPU_RD_LO, `IDX_CPU_CFG,
			`IDX_HYST_HI, `IDX_HYST_LO, `IDX_OVT_HI, `IDX_OVT_LO,
			`IDX_SENSE_TYPE, `IDX_CRIT_EN, `IDX_MAX_OUT, `IDX_STEP,
			`IDX_SYS_CRIT, `IDX_CPU_CRIT, `IDX_FAN_MODE, `IDX_CPU_TARGET,
			`IDX_CPU_BASE, `IDX_SYS_BASE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = (a[ADDR_W-1:10] == '0) && mapped(a[9:2]);
	endfunction

	assign stop = cfg[`BIT_CFG_STOP];
	assign fan_mode = fan_mode_t'(mode_reg[1:0]);
	assign src_temp = src_sel[0] ? peci_temp : cpu_temp_input;

	// ***************************************************************
	// axi write channel
	// ***************************************************************
	// address and data are held separately, so either may arrive first
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign wr_en = do_write && aw_hit && wstrb0;

	always_comb begin
		next_aw_full = aw_full;
		next_w_full = w_full;
		next_aw_idx = aw_idx;
		next_aw_hit = aw_hit;
		next_wbyte = wbyte;
		next_wstrb0 = wstrb0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_idx = s_axi_awaddr[9:2];
			next_aw_hit = addr_ok(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
			next_wbyte = s_axi_wdata[7:0];
			next_wstrb0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = aw_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_idx <= 8'h00;
			aw_hit <= 1'b0;
			wbyte <= 8'h00;
			wstrb0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			aw_idx <= next_aw_idx;
			aw_hit <= next_aw_hit;
			wbyte <= next_wbyte;
			wstrb0 <= next_wstrb0;
			s_axi_awready <= !next_aw_full;
			s_axi_wready <= !next_w_full;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
		end
	end

	// ***************************************************************
	// axi read channel
	// ***************************************************************
	assign ar_take = s_axi_arvalid && s_axi_arready;

	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_arready = s_axi_arready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (ar_take) begin
			next_rvalid = 1'b1;
			next_arready = 1'b0;
			next_rresp = addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			next_rdata = 32'h0000_0000;
			if (s_axi_araddr[ADDR_W-1:10] == '0) begin
				case (s_axi_araddr[9:2])
					`IDX_SRC_SEL: next_rdata[7:0] = src_sel;
					`IDX_CPU_RD_HI: next_rdata[7:0] = cpu_reading[8:1];
					`IDX_CPU_RD_LO: next_rdata[7:0] = {cpu_reading[0], 7'h00};
					`IDX_CPU_CFG: next_rdata[7:0] = cfg;
					`IDX_HYST_HI: next_rdata[7:0] = hyst_hi;
					`IDX_HYST_LO: next_rdata[7:0] = hyst_lo;
					`IDX_OVT_HI: next_rdata[7:0] = ovt_hi;
					`IDX_OVT_LO: next_rdata[7:0] = ovt_lo;
					`IDX_SENSE_TYPE: next_rdata[7:0] = sense_type;
					`IDX_CRIT_EN: next_rdata[7:0] = crit_en;
					`IDX_MAX_OUT: next_rdata[7:0] = max_out;
					`IDX_STEP: next_rdata[7:0] = step_val;
					`IDX_SYS_CRIT: next_rdata[7:0] = sys_crit;
					`IDX_CPU_CRIT: next_rdata[7:0] = cpu_crit;
					`IDX_FAN_MODE: next_rdata[7:0] = mode_reg;
					`IDX_CPU_TARGET: next_rdata[7:0] = cpu_target;
					`IDX_CPU_BASE: next_rdata[7:0] = cpu_base;
					`IDX_SYS_BASE: next_rdata[7:0] = sys_base;
					default: next_rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// ***************************************************************
	// register file
	// ***************************************************************
	// reserved bits are masked on write and so always read as zero
	always_comb begin
		next_crit_en = crit_en;
		next_max_out = max_out;
		next_step_val = step_val;
		next_sys_crit = sys_crit;
		next_cpu_crit = cpu_crit;
		next_cfg = cfg;
		next_hyst_hi = hyst_hi;
		next_hyst_lo = hyst_lo;
		next_ovt_hi = ovt_hi;
		next_ovt_lo = ovt_lo;
		next_sense_type = sense_type;
		next_src_sel = src_sel;
		next_mode_reg = mode_reg;
		next_cpu_target = cpu_target;
		next_cpu_base = cpu_base;
		next_sys_base = sys_base;
		if (wr_en) begin
			case (aw_idx)
				`IDX_CRIT_EN: next_crit_en = wbyte & `MSK_CRIT_EN;
				`IDX_MAX_OUT: next_max_out = wbyte;
				`IDX_STEP: next_step_val = wbyte;
				`IDX_SYS_CRIT: next_sys_crit = wbyte;
				`IDX_CPU_CRIT: next_cpu_crit = wbyte;
				`IDX_CPU_CFG: next_cfg = wbyte & `MSK_CFG;
				`IDX_HYST_HI: next_hyst_hi = wbyte;
				`IDX_HYST_LO: next_hyst_lo = wbyte & `MSK_LO_BYTE;
				`IDX_OVT_HI: next_ovt_hi = wbyte;
				`IDX_OVT_LO: next_ovt_lo = wbyte & `MSK_LO_BYTE;
				`IDX_SENSE_TYPE: next_sense_type = wbyte & `MSK_SENSE_TYPE;
				`IDX_SRC_SEL: next_src_sel = wbyte & `MSK_SRC_SEL;
				`IDX_FAN_MODE: next_mode_reg = wbyte & `MSK_FAN_MODE;
				`IDX_CPU_TARGET: next_cpu_target = wbyte;
				`IDX_CPU_BASE: next_cpu_base = wbyte;
				`IDX_SYS_BASE: next_sys_base = wbyte;
				default: next_mode_reg = mode_reg;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			crit_en <= `RST_CRIT_EN;
			max_out <= `RST_MAX_OUT;
			step_val <= `RST_STEP;
			sys_crit <= `RST_CRIT_TEMP;
			cpu_crit <= `RST_CRIT_TEMP;
			cfg <= `RST_ZERO;
			hyst_hi <= `RST_HYST_HI;
			hyst_lo <= `RST_ZERO;
			ovt_hi <= `RST_OVT_HI;
			ovt_lo <= `RST_ZERO;
			sense_type <= `RST_SENSE_TYPE;
			src_sel <= `RST_ZERO;
			mode_reg <= `RST_ZERO;
			cpu_target <= `RST_CPU_TARGET;
			cpu_base <= `RST_ZERO;
			sys_base <= `RST_ZERO;
		end else begin
			crit_en <= next_crit_en;
			max_out <= next_max_out;
			step_val <= next_step_val;
			sys_crit <= next_sys_crit;
			cpu_crit <= next_cpu_crit;
			cfg <= next_cfg;
			hyst_hi <= next_hyst_hi;
			hyst_lo <= next_hyst_lo;
			ovt_hi <= next_ovt_hi;
			ovt_lo <= next_ovt_lo;
			sense_type <= next_sense_type;
			src_sel <= next_src_sel;
			mode_reg <= next_mode_reg;
			cpu_target <= next_cpu_target;
			cpu_base <= next_cpu_base;
			sys_base <= next_sys_base;
		end
	end

	// ***************************************************************
	// readings, alert and fan drive
	// ***************************************************************
	assign aif.sample = temp_sample;
	assign aif.reading = src_temp;
	assign aif.over_thr = {ovt_hi, ovt_lo[7]};
	assign aif.hyst_thr = {hyst_hi, hyst_lo[7]};
	assign aif.fault_cfg = cfg[`BIT_CFG_FAULT_HI:`BIT_CFG_FAULT_LO];
	assign aif.int_mode = cfg[`BIT_CFG_MODE];
	assign aif.stop = stop;
	// reading the high byte acknowledges an interrupt-mode alert
	assign aif.clear = ar_take && s_axi_araddr[ADDR_W-1:10] == '0
		&& s_axi_araddr[9:2] == `IDX_CPU_RD_HI;

	over_temp_monitor u_mon (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.ifc(aif.mon)
	);

	// saturating step arithmetic; a lowered ceiling pulls the output down at once
	assign fan_sum = {1'b0, cpu_fan_drive_out} + {1'b0, step_val};
	assign fan_up = (fan_sum > {1'b0, max_out}) ? max_out : fan_sum[7:0];
	assign fan_hold = (cpu_fan_drive_out > max_out) ? max_out : cpu_fan_drive_out;
	assign fan_dn = (cpu_fan_drive_out < step_val) ? 8'h00 : cpu_fan_drive_out - step_val;

	always_comb begin
		next_cpu_reading = cpu_reading;
		next_sys_reading = sys_reading;
		next_cpu_fan = cpu_base;
		next_sys_fan = sys_base;
		if (temp_sample) begin
			next_sys_reading = sys_temp_input;
			if (!stop) begin
				next_cpu_reading = src_temp;
			end
		end
		case (fan_mode)
			FAN_STEPPED: begin
				next_cpu_fan = fan_hold;
				if (temp_sample && !stop && src_temp[8:1] > cpu_target) begin
					next_cpu_fan = fan_up;
				end else if (temp_sample && !stop && src_temp[8:1] < cpu_target) begin
					next_cpu_fan = (fan_dn > max_out) ? max_out : fan_dn;
				end
			end
			FAN_TARGET: begin
				if (crit_en[`BIT_CPU_CRIT_EN] && cpu_reading[8:1] > cpu_crit) begin
					next_cpu_fan = `FAN_FULL;
				end
				if (crit_en[`BIT_SYS_CRIT_EN] && sys_reading[8:1] > sys_crit) begin
					next_sys_fan = `FAN_FULL;
				end
			end
			default: next_cpu_fan = cpu_base;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cpu_reading <= `RST_READING;
			sys_reading <= `RST_READING;
			cpu_fan_drive_out <= `RST_ZERO;
			sys_fan_drive_out <= `RST_ZERO;
			over_temp_alert_n <= 1'b1;
			cpu_sense_current_mode <= 1'b0;
			sys_sense_current_mode <= 1'b0;
			cpu_sensor_type_select <= 1'b0;
			sys_sensor_type_select <= 1'b0;
		end else begin
			cpu_reading <= next_cpu_reading;
			sys_reading <= next_sys_reading;
			cpu_fan_drive_out <= next_cpu_fan;
			sys_fan_drive_out <= next_sys_fan;
			over_temp_alert_n <= !aif.alert;
			// current mode needs both its enable and the diode type bit
			cpu_sense_current_mode <= crit_en[`BIT_CPU_CURRENT] & sense_type[`BIT_CPU_TYPE];
			sys_sense_current_mode <= crit_en[`BIT_SYS_CURRENT] & sense_type[`BIT_SYS_TYPE];
			cpu_sensor_type_select <= sense_type[`BIT_CPU_TYPE];
			sys_sensor_type_select <= sense_type[`BIT_SYS_TYPE];
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_step_rise;
		fan_mode == FAN_STEPPED && temp_sample && !stop && src_temp[8:1] > cpu_target
		&& fan_sum <= {1'b0, max_out};
	endsequence

	a_cpu_crit_full: assert property (
		fan_mode == FAN_TARGET && crit_en[5] && cpu_reading[8:1] > cpu_crit
		|=> cpu_fan_drive_out == 8'hFF)
		else $error("cpu fan not full above critical temperature");
	a_sys_crit_full: assert property (
		fan_mode == FAN_TARGET && crit_en[4] && sys_reading[8:1] > sys_crit
		|=> sys_fan_drive_out == 8'hFF)
		else $error("sys fan not full above critical temperature");
	a_step_ceiling: assert property (
		fan_mode == FAN_STEPPED |=> cpu_fan_drive_out <= $past(max_out))
		else $error("stepped cpu fan above maximum");
	a_step_add: assert property (
		s_step_rise |=> cpu_fan_drive_out == $past(fan_sum[7:0]))
		else $error("stepped cpu fan did not rise by step");
	a_reading_capture: assert property (
		temp_sample && !stop |=> cpu_reading == $past(src_temp))
		else $error("cpu reading not captured");
	a_reading_frozen: assert property (
		stop ##1 $stable(cfg) |-> $stable(cpu_reading))
		else $error("cpu reading changed while stopped");
	a_source_select: assert property (
		temp_sample && !stop && src_sel[0] |=> cpu_reading == $past(peci_temp))
		else $error("digital source not selected");
	a_alert_follow: assert property (
		aif.alert |=> !over_temp_alert_n)
		else $error("alert pin does not follow monitor");
endmodule

// file: logic/fan_ctrl_consts.svh
`ifndef FAN_CTRL_CONSTS_SVH
`define FAN_CTRL_CONSTS_SVH

// ***************************************************************
// register indices; byte address is four times the index
// ***************************************************************
`define IDX_SRC_SEL 8'h49
`define IDX_CPU_RD_HI 8'h50
`define IDX_CPU_RD_LO 8'h51
`define IDX_CPU_CFG 8'h52
`define IDX_HYST_HI 8'h53
`define IDX_HYST_LO 8'h54
`define IDX_OVT_HI 8'h55
`define IDX_OVT_LO 8'h56
`define IDX_SENSE_TYPE 8'h5D
`define IDX_CRIT_EN 8'h5E
`define IDX_MAX_OUT 8'h67
`define IDX_STEP 8'h68
`define IDX_SYS_CRIT 8'h6B
`define IDX_CPU_CRIT 8'h6C
`define IDX_FAN_MODE 8'h70
`define IDX_CPU_TARGET 8'h71
`define IDX_CPU_BASE 8'h72
`define IDX_SYS_BASE 8'h73

// ***************************************************************
// reset values
// ***************************************************************
`define RST_ZERO 8'h00
`define RST_CRIT_EN 8'h04
`define RST_SENSE_TYPE 8'h04
`define RST_MAX_OUT 8'hFF
`define RST_STEP 8'h01
`define RST_CRIT_TEMP 8'hFF
`define RST_HYST_HI 8'h4B
`define RST_OVT_HI 8'h50
`define RST_CPU_TARGET 8'h32
`define RST_READING 9'h000

// ***************************************************************
// writable bit masks and field positions
// ***************************************************************
`define MSK_CRIT_EN 8'h36
`define MSK_CFG 8'h1B
`define MSK_LO_BYTE 8'h80
`define MSK_SENSE_TYPE 8'h06
`define MSK_SRC_SEL 8'h01
`define MSK_FAN_MODE 8'h03
`define BIT_CPU_CRIT_EN 5
`define BIT_SYS_CRIT_EN 4
`define BIT_CPU_CURRENT 2
`define BIT_SYS_CURRENT 1
`define BIT_CPU_TYPE 2
`define BIT_SYS_TYPE 1
`define BIT_CFG_STOP 0
`define BIT_CFG_MODE 1
`define BIT_CFG_FAULT_HI 4
`define BIT_CFG_FAULT_LO 3
`define FAN_FULL 8'hFF
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: logic/fan_ctrl_pkg.sv
package fan_ctrl_pkg;
	typedef logic [7:0] reg8_t;
	typedef logic [8:0] temp9_t;
	typedef logic [1:0] resp_t;
	typedef enum logic [1:0] {FAN_MANUAL, FAN_STEPPED, FAN_TARGET} fan_mode_t;
endpackage

// file: logic/alert_if.sv
`timescale 1ns/1ps
interface alert_if;
	import fan_ctrl_pkg::*;
	logic sample;
	temp9_t reading;
	temp9_t over_thr;
	temp9_t hyst_thr;
	logic [1:0] fault_cfg;
	logic int_mode;
	logic stop;
	logic clear;
	logic alert;
	modport ctl(output sample, reading, over_thr, hyst_thr, fault_cfg, int_mode, stop, clear,
		input alert);
	modport mon(input sample, reading, over_thr, hyst_thr, fault_cfg, int_mode, stop, clear,
		output alert);
endinterface

// file: logic/over_temp_monitor.sv
`timescale 1ns/1ps
module over_temp_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// alert channel
	alert_if.mon ifc
);
	import fan_ctrl_pkg::*;

	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic next_alert;
	logic [2:0] need;
	logic take;
	logic over;

	assign need = {1'b0, ifc.fault_cfg} + 3'd1;
	assign take = ifc.sample & ~ifc.stop;
	assign over = ifc.reading > ifc.over_thr;

	// ***************************************************************
	// fault counting and alert
	// ***************************************************************
	always_comb begin
		next_cnt = cnt;
		next_alert = ifc.alert;
		// clear comes first so that a trip in the same cycle wins
		if (ifc.int_mode && ifc.clear && !ifc.stop) begin
			next_alert = 1'b0;
		end
		if (take) begin
			if (over) begin
				if (cnt < need) begin
					next_cnt = cnt + 3'd1;
				end
				if (cnt + 3'd1 >= need) begin
					next_alert = 1'b1;
				end
			end else begin
				next_cnt = 3'd0;
				if (!ifc.int_mode && ifc.reading < ifc.hyst_thr) begin
					next_alert = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cnt <= 3'd0;
			ifc.alert <= 1'b0;
		end else begin
			cnt <= next_cnt;
			ifc.alert <= next_alert;
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_over_sample;
		ifc.sample && !ifc.stop && ifc.reading > ifc.over_thr;
	endsequence

	a_first_fault_trip: assert property (
		(ifc.fault_cfg == 2'd0) and s_over_sample |=> ifc.alert)
		else $error("alert not raised on first fault");
	a_fault_count_wait: assert property (
		(ifc.fault_cfg == 2'd1 && cnt == 3'd0 && !ifc.alert && !ifc.int_mode) and s_over_sample
		|=> !ifc.alert)
		else $error("alert raised before fault count reached");
	a_cmp_release: assert property (
		!ifc.int_mode && ifc.sample && !ifc.stop && ifc.reading < ifc.hyst_thr
		&& ifc.reading <= ifc.over_thr |=> !ifc.alert)
		else $error("comparator alert not released below hysteresis");
	a_int_mode_latch: assert property (
		ifc.int_mode && ifc.alert && !ifc.clear |=> ifc.alert)
		else $error("interrupt mode alert dropped without clear");
	a_stop_hold: assert property (
		ifc.stop |=> $stable(ifc.alert))
		else $error("alert changed while monitoring stopped");
endmodule

// file: test/sensor_model.sv
`timescale 1ns/1ps
module sensor_model (
	// clock
	input wire logic sys_clk,
	// request from the bench
	input wire logic go,
	input wire fan_ctrl_pkg::temp9_t cpu_req,
	input wire fan_ctrl_pkg::temp9_t peci_req,
	input wire fan_ctrl_pkg::temp9_t sys_req,
	// sensor side
	output fan_ctrl_pkg::temp9_t cpu_temp_input,
	output fan_ctrl_pkg::temp9_t peci_temp,
	output fan_ctrl_pkg::temp9_t sys_temp_input,
	output logic temp_sample
);
	import fan_ctrl_pkg::*;
	// ****************************************
	// conversion results
	// ****************************************
	initial begin
		temp_sample = 1'b0;
		cpu_temp_input = 9'h000;
		peci_temp = 9'h000;
		sys_temp_input = 9'h000;
	end
	// off the strobe the lines toggle, so reading them then gives junk
	always @(posedge sys_clk) begin
		temp_sample <= go;
		cpu_temp_input <= go ? cpu_req : ~cpu_temp_input;
		peci_temp <= go ? peci_req : ~peci_temp;
		sys_temp_input <= go ? sys_req : ~sys_temp_input;
	end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
`include "fan_ctrl_consts.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
	import fan_ctrl_pkg::*;
	logic sys_clk, resetn, go;
	logic [11:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, tsmp;
	logic [31:0] wdata, rdata;
	resp_t bresp, rresp;
	temp9_t cq, sq, cpu_t, peci_t, sys_t;
	reg8_t cpu_fan_drive_out, sys_fan_drive_out;
	logic over_temp_alert_n, cpu_sense_current_mode, sys_sense_current_mode;
	logic cpu_sensor_type_select, sys_sensor_type_select;
	int mismatches, check_count;
	// ****************************************
	// design and sensors
	// ****************************************
	fan_temp_regs #(.ADDR_W(12)) dut (.sys_clk(sys_clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.cpu_temp_input(cpu_t), .peci_temp(peci_t), .sys_temp_input(sys_t), .temp_sample(tsmp),
		.cpu_fan_drive_out(cpu_fan_drive_out), .sys_fan_drive_out(sys_fan_drive_out),
		.over_temp_alert_n(over_temp_alert_n), .cpu_sense_current_mode(cpu_sense_current_mode),
		.sys_sense_current_mode(sys_sense_current_mode),
		.cpu_sensor_type_select(cpu_sensor_type_select),
		.sys_sensor_type_select(sys_sensor_type_select));
	sensor_model sensors (.sys_clk(sys_clk), .go(go), .cpu_req(cq), .peci_req(9'h101),
		.sys_req(sq), .cpu_temp_input(cpu_t), .peci_temp(peci_t), .sys_temp_input(sys_t),
		.temp_sample(tsmp));
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;
	// ****************************************
	// bus and sensor tasks
	// ****************************************
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input resp_t er = `RESP_OKAY);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		`CHK(bresp, er)
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input resp_t er = `RESP_OKAY);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		`CHK(rdata, {24'h0, e})
		`CHK(rresp, er)
	endtask
	// alert settles two edges after the sample, so wait past that
	task automatic smp(input temp9_t c, input temp9_t s);
		cq <= c;
		sq <= s;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		`CHK(cpu_fan_drive_out, 8'h00)
		`CHK(over_temp_alert_n, 1'b1)
		`CHK(cpu_sense_current_mode, 1'b1)
		`CHK(sys_sense_current_mode, 1'b0)
		`CHK(cpu_sensor_type_select, 1'b1)
		`CHK(sys_sensor_type_select, 1'b0)
		rd(`IDX_CRIT_EN, 8'h04);
		rd(`IDX_MAX_OUT, 8'hFF);
		rd(`IDX_STEP, 8'h01);
		rd(`IDX_SYS_CRIT, 8'hFF);
		rd(`IDX_CPU_CRIT, 8'hFF);
		rd(`IDX_CPU_CFG, 8'h00);
		rd(`IDX_HYST_HI, 8'h4B);
		rd(`IDX_OVT_HI, 8'h50);
		rd(8'h60, 8'h00, `RESP_SLVERR);
		wr(8'h60, 8'h12, `RESP_SLVERR);
	endtask
	task automatic t_reading();
		smp(9'h095, 9'h000);
		rd(`IDX_CPU_RD_HI, 8'h4A);
		rd(`IDX_CPU_RD_LO, 8'h80);
		wr(`IDX_CPU_RD_HI, 8'hFF);
		rd(`IDX_CPU_RD_HI, 8'h4A);
		wr(`IDX_CPU_CFG, 8'h1B);
		rd(`IDX_CPU_CFG, 8'h1B);
		wr(`IDX_CPU_CFG, 8'h00);
		wr(`IDX_SRC_SEL, 8'h01);
		smp(9'h095, 9'h000);
		rd(`IDX_CPU_RD_HI, 8'h80);
		wr(`IDX_SRC_SEL, 8'h00);
		smp(9'h095, 9'h000);
		rd(`IDX_CPU_RD_HI, 8'h4A);
	endtask
	task automatic t_critical();
		wr(`IDX_FAN_MODE, 8'h02);
		wr(`IDX_SYS_CRIT, 8'h40);
		wr(`IDX_CPU_CRIT, 8'h40);
		wr(`IDX_SENSE_TYPE, 8'h06);
		wr(`IDX_CRIT_EN, 8'h36);
		smp(9'h082, 9'h082);
		`CHK(cpu_fan_drive_out, 8'hFF)
		`CHK(sys_fan_drive_out, 8'hFF)
		`CHK(sys_sense_current_mode, 1'b1)
		`CHK(sys_sensor_type_select, 1'b1)
		wr(`IDX_CRIT_EN, 8'h20);
		smp(9'h082, 9'h082);
		`CHK(cpu_fan_drive_out, 8'hFF)
		`CHK(sys_fan_drive_out, 8'h00)
		`CHK(cpu_sense_current_mode, 1'b0)
		smp(9'h080, 9'h080);
		`CHK(cpu_fan_drive_out, 8'h00)
		wr(`IDX_SENSE_TYPE, 8'h00);
		// the pin is registered one edge after the register lands
		@(posedge sys_clk);
		`CHK(cpu_sensor_type_select, 1'b0)
		`CHK(sys_sensor_type_select, 1'b0)
	endtask
	task automatic t_stepped();
		int i;
		wr(`IDX_FAN_MODE, 8'h01);
		wr(`IDX_CPU_TARGET, 8'h40);
		wr(`IDX_STEP, 8'h10);
		wr(`IDX_MAX_OUT, 8'h30);
		repeat (3) smp(9'h060, 9'h060);
		`CHK(cpu_fan_drive_out, 8'h00)
		for (i = 1; i <= 4; i++) begin
			smp(9'h0A0, 9'h0A0);
			`CHK(cpu_fan_drive_out, (i < 4) ? 8'(16 * i) : 8'h30)
		end
		smp(9'h060, 9'h060);
		`CHK(cpu_fan_drive_out, 8'h20)
		wr(`IDX_FAN_MODE, 8'h00);
	endtask
	task automatic t_alert();
		wr(`IDX_CPU_CFG, 8'h08);
		smp(9'h0B0, 9'h000);
		`CHK(over_temp_alert_n, 1'b1)
		smp(9'h0B0, 9'h000);
		`CHK(over_temp_alert_n, 1'b0)
		smp(9'h096, 9'h000);
		`CHK(over_temp_alert_n, 1'b0)
		smp(9'h090, 9'h000);
		`CHK(over_temp_alert_n, 1'b1)
		wr(`IDX_CPU_CFG, 8'h09);
		repeat (2) smp(9'h0B0, 9'h000);
		`CHK(over_temp_alert_n, 1'b1)
		rd(`IDX_CPU_RD_HI, 8'h48);
		wr(`IDX_CPU_CFG, 8'h02);
		smp(9'h0B0, 9'h000);
		`CHK(over_temp_alert_n, 1'b0)
		smp(9'h090, 9'h000);
		`CHK(over_temp_alert_n, 1'b0)
		rd(`IDX_CPU_RD_HI, 8'h48);
		repeat (2) @(posedge sys_clk);
		`CHK(over_temp_alert_n, 1'b1)
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		resetn <= 1'b0;
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		arvalid <= 1'b0;
		awaddr <= 12'h000;
		araddr <= 12'h000;
		wdata <= 32'h0;
		go <= 1'b0;
		cq <= 9'h000;
		sq <= 9'h000;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		// outputs launched at the first edge after release are settled only by the next
		repeat (2) @(posedge sys_clk);
		t_reset();
		t_reading();
		t_critical();
		t_stepped();
		t_alert();
		tally_and_finish();
	end
	// a few hundred cycles are expected; this is far beyond
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		tally_and_finish();
	end
endmodule
